// *** include/cswlh_pkg.sv ***
`default_nettype none

package cswlh_pkg;

    // ----------------------------------------------------------------
    // Instruction classes seen by the sequencing model
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NOP,
        OP_OTHER,
        OP_BIS_SW,
        OP_INT_ENABLE,
        OP_MULTI_POP_SW,
        OP_CALL,
        OP_CALLA,
        OP_ROTM,
        OP_IND_PC_SRC
    } cswlh_op_t;

    typedef enum logic [2:0] {
        AM_REG,
        AM_IDX,
        AM_ABS,
        AM_SYM,
        AM_IND,
        AM_INC,
        AM_IMM
    } cswlh_am_t;

    typedef enum logic [1:0] {
        ROT_RRC,
        ROT_RRA,
        ROT_RRU,
        ROT_RLA
    } cswlh_rot_t;

    typedef enum logic {
        PUSH_PC,
        PUSH_SW
    } cswlh_push_t;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        cswlh_op_t  op;
        cswlh_am_t  src_am;
        logic       dst_pc;
        cswlh_rot_t rot;
        logic       sets_halt;
        logic       sets_gie;
    } cswlh_instr_t;

    typedef struct packed {
        logic pc_pair;
        logic dma_pair;
        logic rot_pair;
    } cswlh_haz_t;

    typedef struct packed {
        logic hang;
        logic unpredictable;
        logic pc_corrupt;
        logic dma_blocked;
    } cswlh_fault_t;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam cswlh_fault_t FAULT_RST = '0;
    localparam cswlh_instr_t INSTR_RST = '0;
    localparam logic         GIE_RST   = 1'b0;
    localparam logic         HALT_RST  = 1'b0;

    // ----------------------------------------------------------------
    // Shared decoding
    // ----------------------------------------------------------------
    function automatic logic is_call(input cswlh_op_t op);
        is_call = (op == OP_CALL) || (op == OP_CALLA);
    endfunction

    function automatic logic call_mode_hit(input cswlh_am_t am);
        call_mode_hit = (am == AM_IND) || (am == AM_INC) || (am == AM_REG);
    endfunction

endpackage

`default_nettype wire

// *** design/cswlh_hazard.sv ***
`default_nettype none

module cswlh_hazard (
    input  wire logic                   i_prev_vld,
    input  wire cswlh_pkg::cswlh_instr_t i_prev,
    input  wire cswlh_pkg::cswlh_instr_t i_cur,
    output cswlh_pkg::cswlh_haz_t        o_haz
);

    logic bis_like;
    logic bis_src_hit;
    logic dma_src_hit;

    always_comb
    begin
        bis_like    = (i_prev.op == cswlh_pkg::OP_BIS_SW) || (i_prev.op == cswlh_pkg::OP_INT_ENABLE);
        bis_src_hit = (i_prev.op == cswlh_pkg::OP_INT_ENABLE)
                      || (i_prev.src_am == cswlh_pkg::AM_ABS)
                      || (i_prev.src_am == cswlh_pkg::AM_IDX)
                      || (i_prev.src_am == cswlh_pkg::AM_REG);
        dma_src_hit = (i_prev.src_am == cswlh_pkg::AM_REG) || (i_prev.src_am == cswlh_pkg::AM_IDX)
                      || (i_prev.src_am == cswlh_pkg::AM_ABS) || (i_prev.src_am == cswlh_pkg::AM_SYM);

        // Halt or interrupt-enable write directly followed by an affected call
        o_haz.pc_pair = i_prev_vld && bis_like && bis_src_hit
                        && (i_prev.sets_halt || i_prev.sets_gie || (i_prev.op == cswlh_pkg::OP_INT_ENABLE))
                        && cswlh_pkg::is_call(i_cur.op)
                        && cswlh_pkg::call_mode_hit(i_cur.src_am);

        // Low-power entry directly followed by register-mode extended call
        o_haz.dma_pair = i_prev_vld && (i_prev.op == cswlh_pkg::OP_BIS_SW) && i_prev.sets_halt
                         && dma_src_hit
                         && (i_cur.op == cswlh_pkg::OP_CALLA)
                         && (i_cur.src_am == cswlh_pkg::AM_REG);

        // Only directly adjacent rotates on the program counter
        o_haz.rot_pair = i_prev_vld && (i_prev.op == cswlh_pkg::OP_ROTM) && i_prev.dst_pc
                         && (i_cur.op == cswlh_pkg::OP_ROTM) && i_cur.dst_pc;
    end

endmodule

`default_nettype wire

// *** design/cswlh_core.sv ***
`default_nettype none

module cswlh_core (
    input  wire logic                   i_clk,
    input  wire logic                   i_rst_n,
    input  wire logic                   i_instr_valid,
    input  wire cswlh_pkg::cswlh_instr_t i_instr,
    input  wire logic                   i_irq,
    input  wire logic                   i_dma_req,
    input  wire logic                   i_dma_rmw_hold_off,
    output logic                        o_instr_ready,
    output logic                        o_retire,
    output logic                        o_retire_skipped,
    output logic                        o_halted,
    output logic                        o_gie,
    output logic                        o_push_valid,
    output cswlh_pkg::cswlh_push_t       o_push_kind,
    output logic                        o_dma_ack,
    output cswlh_pkg::cswlh_fault_t      o_fault
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN,
        ST_PUSH_PC,
        ST_PUSH_SW,
        ST_HUNG
    } cswlh_state_t;

    cswlh_state_t            state_r;
    cswlh_state_t            state_nxt;
    cswlh_pkg::cswlh_instr_t prev_r;
    logic                    prev_vld_r;
    logic                    skip_r;
    logic                    halted_r;
    logic                    halted_nxt;
    logic                    gie_r;
    logic                    irq_d_r;
    logic                    arm_irq_r;
    logic                    corrupt_pend_r;
    logic                    dma_block_r;
    cswlh_pkg::cswlh_haz_t   haz;

    logic take;
    logic eff;
    logic halting;
    logic hang_now;
    logic irq_go;
    logic corrupt_now;
    logic bis_exec;

    // ----------------------------------------------------------------
    // Pair detection against the previously executed instruction
    // ----------------------------------------------------------------
    cswlh_hazard u_hazard (
        .i_prev_vld (prev_vld_r),
        .i_prev     (prev_r),
        .i_cur      (i_instr),
        .o_haz      (haz)
    );

    // ----------------------------------------------------------------
    // Decode of the current cycle
    // ----------------------------------------------------------------
    always_comb
    begin
        take     = i_instr_valid && o_instr_ready;
        eff      = take && !skip_r;
        halting  = eff && i_instr.sets_halt
                   && ((i_instr.op == cswlh_pkg::OP_BIS_SW) || (i_instr.op == cswlh_pkg::OP_MULTI_POP_SW));
        hang_now = eff && (i_instr.op == cswlh_pkg::OP_MULTI_POP_SW) && i_instr.sets_halt && i_irq;
        bis_exec = eff && ((i_instr.op == cswlh_pkg::OP_BIS_SW) || (i_instr.op == cswlh_pkg::OP_INT_ENABLE));
        // Interrupt seen one cycle before, at, or one cycle after the bit-set
        corrupt_now = eff && haz.pc_pair && (arm_irq_r || i_irq);
        irq_go   = (state_r == ST_RUN) && i_irq && gie_r && !halting && !hang_now;
    end

    // ----------------------------------------------------------------
    // Sequencer state
    // ----------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_RUN:
            begin
                if (hang_now)
                    state_nxt = ST_HUNG;
                else if (irq_go)
                    state_nxt = ST_PUSH_PC;
            end
            ST_PUSH_PC:
                state_nxt = ST_PUSH_SW;
            ST_PUSH_SW:
                state_nxt = ST_RUN;
            ST_HUNG:
                state_nxt = ST_HUNG;
        endcase
    end

    always_comb
    begin
        halted_nxt = halted_r;
        if (irq_go)
            halted_nxt = 1'b0;
        else if (halting)
            halted_nxt = 1'b1;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            state_r <= ST_RUN;
        else
            state_r <= state_nxt;
    end

    // Halt takes effect after the one already-fetched instruction slot
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            halted_r      <= cswlh_pkg::HALT_RST;
            o_instr_ready <= 1'b0;
        end
        else
        begin
            halted_r      <= halted_nxt;
            o_instr_ready <= (state_nxt == ST_RUN) && (!halted_nxt || (halting && !halted_r));
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            gie_r <= cswlh_pkg::GIE_RST;
        else if (irq_go)
            gie_r <= 1'b0;
        else if (eff && ((i_instr.op == cswlh_pkg::OP_INT_ENABLE)
                         || ((i_instr.op == cswlh_pkg::OP_BIS_SW) && i_instr.sets_gie)))
            gie_r <= 1'b1;
    end

    // ----------------------------------------------------------------
    // Instruction history
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            prev_r     <= cswlh_pkg::INSTR_RST;
            prev_vld_r <= 1'b0;
        end
        else if (irq_go)
            prev_vld_r <= 1'b0;
        else if (eff)
        begin
            prev_r     <= i_instr;
            prev_vld_r <= 1'b1;
        end
        else if (take)
            prev_vld_r <= 1'b0;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            skip_r <= 1'b0;
        else if (take)
            skip_r <= eff && (i_instr.op == cswlh_pkg::OP_IND_PC_SRC);
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_retire         <= 1'b0;
            o_retire_skipped <= 1'b0;
        end
        else
        begin
            o_retire         <= take;
            o_retire_skipped <= take && skip_r;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt window and stack pushes
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            irq_d_r   <= 1'b0;
            arm_irq_r <= 1'b0;
        end
        else
        begin
            irq_d_r   <= i_irq;
            arm_irq_r <= bis_exec && (i_irq || irq_d_r);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            corrupt_pend_r <= 1'b0;
        else if (corrupt_now)
            corrupt_pend_r <= 1'b1;
        else if (state_r == ST_PUSH_SW)
            corrupt_pend_r <= 1'b0;
    end

    // Entry pushes counter then status word; a corrupted entry pushes the counter twice
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_push_valid <= 1'b0;
            o_push_kind  <= cswlh_pkg::PUSH_PC;
        end
        else
        begin
            o_push_valid <= (state_nxt == ST_PUSH_PC) || (state_nxt == ST_PUSH_SW);
            if ((state_nxt == ST_PUSH_SW) && !corrupt_pend_r)
                o_push_kind <= cswlh_pkg::PUSH_SW;
            else
                o_push_kind <= cswlh_pkg::PUSH_PC;
        end
    end

    // ----------------------------------------------------------------
    // DMA service
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            dma_block_r <= 1'b0;
        else if (irq_go || !halted_nxt)
            dma_block_r <= 1'b0;
        else if (eff && haz.dma_pair && i_dma_rmw_hold_off)
            dma_block_r <= 1'b1;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_dma_ack <= 1'b0;
        else
            o_dma_ack <= i_dma_req && !dma_block_r;
    end

    // ----------------------------------------------------------------
    // Visible state
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_halted <= cswlh_pkg::HALT_RST;
            o_gie    <= cswlh_pkg::GIE_RST;
            o_fault  <= cswlh_pkg::FAULT_RST;
        end
        else
        begin
            o_halted             <= halted_nxt;
            o_gie                <= gie_r;
            o_fault.dma_blocked  <= dma_block_r;
            if (hang_now)
                o_fault.hang <= 1'b1;
            if (eff && haz.rot_pair)
                o_fault.unpredictable <= 1'b1;
            if ((state_r == ST_PUSH_PC) && corrupt_pend_r)
                o_fault.pc_corrupt <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_push_pair(cswlh_pkg::cswlh_push_t k2);
        o_push_valid && (o_push_kind == cswlh_pkg::PUSH_PC) ##1 o_push_valid && (o_push_kind == k2);
    endsequence

    sequence s_hung;
        (!o_instr_ready && (state_r == ST_HUNG))[*4];
    endsequence

    AST_HANG: assert property (hang_now |=> s_hung ##0 o_fault.hang)
        else $error("halting pop with pending interrupt did not hang");
    AST_SKIP_ARM: assert property (eff && (i_instr.op == cswlh_pkg::OP_IND_PC_SRC) |=> skip_r)
        else $error("indirect counter source did not arm skip");
    AST_SKIP_RET: assert property (take && skip_r |=> o_retire && o_retire_skipped && !skip_r)
        else $error("instruction after indirect counter source not skipped");
    AST_ROT_PAIR: assert property (eff && haz.rot_pair |=> o_fault.unpredictable)
        else $error("adjacent counter rotates not flagged");
    AST_ROT_NOP: assert property (eff && prev_vld_r && (prev_r.op == cswlh_pkg::OP_NOP) && !o_fault.unpredictable
        |=> !o_fault.unpredictable)
        else $error("rotate after no-operation flagged");
    AST_CORRUPT: assert property (irq_go && (corrupt_now || corrupt_pend_r)
        |=> s_push_pair(cswlh_pkg::PUSH_PC))
        else $error("corrupted entry did not push counter twice");
    AST_CALL_MODE: assert property (eff && !cswlh_pkg::call_mode_hit(i_instr.src_am) |-> !haz.pc_pair)
        else $error("unaffected call mode flagged");
    AST_INT_ENABLE: assert property (eff && prev_vld_r && (prev_r.op == cswlh_pkg::OP_INT_ENABLE) && i_irq
        && cswlh_pkg::is_call(i_instr.op) && cswlh_pkg::call_mode_hit(i_instr.src_am)
        |=> corrupt_pend_r)
        else $error("interrupt-enable op followed by call not corrupting");
    AST_NOP_SEP: assert property (eff && prev_vld_r && (prev_r.op == cswlh_pkg::OP_NOP)
        |-> !haz.pc_pair && !haz.dma_pair)
        else $error("no-operation separator did not clear hazard");
    AST_ENTRY: assert property (irq_go && !corrupt_now && !corrupt_pend_r
        |=> s_push_pair(cswlh_pkg::PUSH_SW) ##1 o_instr_ready)
        else $error("entry did not push counter then status word");
    AST_HALT_FETCH: assert property (halted_r && $past(halted_r) |-> !o_instr_ready)
        else $error("fetch not stopped while halted");
    AST_DMA_BLOCK: assert property (dma_block_r && i_dma_req |=> !o_dma_ack)
        else $error("DMA acknowledged while blocked");
    AST_DMA_FREE: assert property (!dma_block_r && i_dma_req |=> o_dma_ack)
        else $error("DMA not serviced while unblocked");
    AST_DMA_HOLD: assert property (eff && haz.dma_pair && !i_dma_rmw_hold_off && !dma_block_r
        |=> !dma_block_r)
        else $error("DMA blocked with hold-off cleared");

endmodule

`default_nettype wire

// *** test/cswlh_src_model.sv ***
`default_nettype none

// ----------------------------------------------------------------
// Interrupt source and DMA controller on the far side of the core
// ----------------------------------------------------------------
module cswlh_src_model (
    input  wire logic  i_clk,
    input  wire logic  i_rst_n,
    input  wire logic  i_irq_cmd,
    input  wire logic  i_dma_run,
    input  wire logic  i_cnt_clr,
    input  wire logic  i_dma_ack,
    output logic       o_irq,
    output logic       o_dma_req,
    output logic [7:0] o_ack_cnt
);
    timeunit 1ns;
    timeprecision 1ps;

    assign o_irq     = i_irq_cmd;
    assign o_dma_req = i_dma_run;

    // Counts serviced DMA cycles so the bench can judge a whole window
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_ack_cnt <= 8'h00;
        else if (i_cnt_clr)
            o_ack_cnt <= 8'h00;
        else if (i_dma_ack)
            o_ack_cnt <= o_ack_cnt + 8'h01;
    end
endmodule

`default_nettype wire

// *** test/tb_cswlh_sr_write_lpm_hazards.sv ***
`default_nettype none
`define CHK(a, e) chk((a) === (e), `__LINE__)

module tb_cpu_sr_write_lpm_hazards;
    timeunit 1ns;
    timeprecision 1ps;

    logic                    i_clk, i_rst_n, i_instr_valid, i_dma_rmw_hold_off;
    logic                    irq_cmd, dma_run, cnt_clr, i_irq, i_dma_req;
    logic                    o_instr_ready, o_retire, o_retire_skipped, o_halted, o_gie;
    logic                    o_push_valid, o_dma_ack;
    logic [7:0]              ack_cnt;
    cswlh_pkg::cswlh_instr_t i_instr;
    cswlh_pkg::cswlh_push_t  o_push_kind;
    cswlh_pkg::cswlh_fault_t o_fault;
    int                      fails = 0;
    int                      samples_checked = 0;

    cswlh_core cswlh_core_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_instr_valid(i_instr_valid),
        .i_instr(i_instr), .i_irq(i_irq), .i_dma_req(i_dma_req), .i_dma_rmw_hold_off(i_dma_rmw_hold_off),
        .o_instr_ready(o_instr_ready), .o_retire(o_retire), .o_retire_skipped(o_retire_skipped),
        .o_halted(o_halted), .o_gie(o_gie), .o_push_valid(o_push_valid), .o_push_kind(o_push_kind),
        .o_dma_ack(o_dma_ack), .o_fault(o_fault));

    cswlh_src_model cswlh_src_model_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_irq_cmd(irq_cmd),
        .i_dma_run(dma_run), .i_cnt_clr(cnt_clr), .i_dma_ack(o_dma_ack), .o_irq(i_irq),
        .o_dma_req(i_dma_req), .o_ack_cnt(ack_cnt));

    always #10 i_clk = ~i_clk;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic ok, input int line);
        samples_checked++;
        if (!ok)
        begin
            fails++;
            $display("[FAIL] %0t ns: mismatch at line %0d", $time, line);
        end
    endtask

    function automatic cswlh_pkg::cswlh_instr_t mk(input cswlh_pkg::cswlh_op_t op,
        input cswlh_pkg::cswlh_am_t am, input logic halt, input logic gie);
        mk           = cswlh_pkg::INSTR_RST;
        mk.op        = op;
        mk.src_am    = am;
        mk.dst_pc    = (op == cswlh_pkg::OP_ROTM);
        mk.sets_halt = halt;
        mk.sets_gie  = gie;
    endfunction

    // Presents one instruction, waits until it is taken, checks its retire pulse
    task automatic issue(input cswlh_pkg::cswlh_instr_t ins, input logic skip);
        int n;
        n             = 0;
        i_instr       = ins;
        i_instr_valid = 1'b1;
        while (o_instr_ready !== 1'b1 && n < 40)
        begin
            @(negedge i_clk);
            n++;
        end
        @(negedge i_clk);
        `CHK(o_retire, 1'b1);
        `CHK(o_retire_skipped, skip);
    endtask

    // Interrupt entry: two back-to-back pushes, then fetch resumes
    task automatic pushes(input cswlh_pkg::cswlh_push_t second);
        int n;
        n = 0;
        while (o_push_valid !== 1'b1 && n < 12)
        begin
            @(negedge i_clk);
            n++;
        end
        `CHK(o_push_kind, cswlh_pkg::PUSH_PC);
        @(negedge i_clk);
        `CHK(o_push_valid, 1'b1);
        `CHK(o_push_kind, second);
        irq_cmd = 1'b0;
        @(negedge i_clk);
        `CHK(o_instr_ready, 1'b1);
        `CHK(o_halted, 1'b0);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_skip();
        issue(mk(cswlh_pkg::OP_IND_PC_SRC, cswlh_pkg::AM_IND, 1'b0, 1'b0), 1'b0);
        issue(mk(cswlh_pkg::OP_OTHER, cswlh_pkg::AM_REG, 1'b0, 1'b0), 1'b1);
        issue(mk(cswlh_pkg::OP_OTHER, cswlh_pkg::AM_REG, 1'b0, 1'b0), 1'b0);
        i_instr_valid = 1'b0;
        $display("test skip done");
    endtask

    task automatic t_rot();
        cswlh_pkg::cswlh_instr_t r;
        r = mk(cswlh_pkg::OP_ROTM, cswlh_pkg::AM_REG, 1'b0, 1'b0);
        for (int k = 0; k < 4; k++)
        begin
            r.rot = cswlh_pkg::cswlh_rot_t'(k);
            issue(r, 1'b0);
            issue(mk(cswlh_pkg::OP_NOP, cswlh_pkg::AM_REG, 1'b0, 1'b0), 1'b0);
        end
        issue(r, 1'b0);
        `CHK(o_fault.unpredictable, 1'b0);
        r.rot = cswlh_pkg::ROT_RRC;
        issue(r, 1'b0);
        i_instr_valid = 1'b0;
        repeat (2) @(negedge i_clk);
        `CHK(o_fault.unpredictable, 1'b1);
        $display("test rotate done");
    endtask

    task automatic t_pc();
        cswlh_pkg::cswlh_am_t src [4] = '{cswlh_pkg::AM_ABS, cswlh_pkg::AM_IDX, cswlh_pkg::AM_REG, cswlh_pkg::AM_REG};
        cswlh_pkg::cswlh_am_t cm [4]  = '{cswlh_pkg::AM_IND, cswlh_pkg::AM_INC, cswlh_pkg::AM_REG, cswlh_pkg::AM_IND};
        issue(mk(cswlh_pkg::OP_INT_ENABLE, cswlh_pkg::AM_REG, 1'b0, 1'b1), 1'b0);
        issue(mk(cswlh_pkg::OP_NOP, cswlh_pkg::AM_REG, 1'b0, 1'b0), 1'b0);
        irq_cmd = 1'b1;
        issue(mk(cswlh_pkg::OP_CALLA, cswlh_pkg::AM_IND, 1'b0, 1'b0), 1'b0);
        i_instr_valid = 1'b0;
        pushes(cswlh_pkg::PUSH_SW);
        `CHK(o_gie, 1'b0);
        `CHK(o_fault.pc_corrupt, 1'b0);
        for (int k = 0; k < 4; k++)
        begin
            issue(mk(k == 3 ? cswlh_pkg::OP_INT_ENABLE : cswlh_pkg::OP_BIS_SW, src[k], 1'b0, 1'b1), 1'b0);
            irq_cmd = 1'b1;
            issue(mk(k[0] ? cswlh_pkg::OP_CALL : cswlh_pkg::OP_CALLA, cm[k], 1'b0, 1'b0), 1'b0);
            i_instr_valid = 1'b0;
            pushes(cswlh_pkg::PUSH_PC);
        end
        `CHK(o_fault.pc_corrupt, 1'b1);
        $display("test counter corruption done");
    endtask

    task automatic t_lp(input logic nop, input logic hold, input cswlh_pkg::cswlh_am_t am, input logic blk);
        issue(mk(cswlh_pkg::OP_INT_ENABLE, cswlh_pkg::AM_REG, 1'b0, 1'b1), 1'b0);
        i_dma_rmw_hold_off = hold;
        issue(mk(cswlh_pkg::OP_BIS_SW, am, 1'b1, 1'b0), 1'b0);
        if (nop)
            issue(mk(cswlh_pkg::OP_NOP, cswlh_pkg::AM_REG, 1'b0, 1'b0), 1'b0);
        else
            issue(mk(cswlh_pkg::OP_CALLA, cswlh_pkg::AM_REG, 1'b0, 1'b0), 1'b0);
        i_instr_valid = 1'b0;
        repeat (2) @(negedge i_clk);
        cnt_clr = 1'b1;
        @(negedge i_clk);
        cnt_clr = 1'b0;
        repeat (8) @(negedge i_clk);
        `CHK(ack_cnt, blk ? 8'h00 : 8'h08);
        `CHK(o_fault.dma_blocked, blk);
        `CHK(o_instr_ready, 1'b0);
        irq_cmd = 1'b1;
        pushes(cswlh_pkg::PUSH_SW);
        i_dma_rmw_hold_off = 1'b0;
        @(negedge i_clk);
        `CHK(o_dma_ack, 1'b1);
        $display("test low power dma done");
    endtask

    task automatic t_hang();
        irq_cmd = 1'b1;
        issue(mk(cswlh_pkg::OP_MULTI_POP_SW, cswlh_pkg::AM_REG, 1'b1, 1'b0), 1'b0);
        i_instr_valid = 1'b0;
        repeat (4) @(negedge i_clk);
        `CHK(o_fault.hang, 1'b1);
        irq_cmd = 1'b0;
        repeat (4) @(negedge i_clk);
        `CHK(o_instr_ready, 1'b0);
        $display("test hang done");
    endtask

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        i_clk = 1'b0;
        i_rst_n = 1'b0;
        i_instr_valid = 1'b0;
        i_instr = cswlh_pkg::INSTR_RST;
        i_dma_rmw_hold_off = 1'b0;
        irq_cmd = 1'b0;
        dma_run = 1'b1;
        cnt_clr = 1'b0;
        repeat (3) @(negedge i_clk);
        `CHK(o_instr_ready, 1'b0);
        `CHK(o_fault, cswlh_pkg::FAULT_RST);
        i_rst_n = 1'b1;
        repeat (2) @(negedge i_clk);
        `CHK(o_instr_ready, 1'b1);
        t_skip();
        t_rot();
        t_pc();
        t_lp(1'b1, 1'b1, cswlh_pkg::AM_REG, 1'b0);
        t_lp(1'b0, 1'b0, cswlh_pkg::AM_IDX, 1'b0);
        t_lp(1'b0, 1'b1, cswlh_pkg::AM_SYM, 1'b1);
        t_hang();
        end_of_test();
    end

    initial
    begin
        repeat (3000) @(posedge i_clk);
        fails++;
        end_of_test();
    end
endmodule

`default_nettype wire
